//--- logic/pmx_defines.svh
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH
// register indices on the plain port and the management frame
`define PMX_REG_CTRL 5'h00
`define PMX_REG_STAT 5'h01
`define PMX_REG_STRAP 5'h10
// basic control fields
`define PMX_CTRL_DUPLEX 8
`define PMX_CTRL_ISOLATE 10
`define PMX_CTRL_SPEED 13
`define PMX_CTRL_RESET 16'h3100
// basic status fields
`define PMX_STAT_LINK 2
`define PMX_STAT_PRE_SUP 6
// management frame
`define PMX_PHY_ADDR_DEF 5'h01
`define PMX_BCAST_ADDR 5'h00
`define PMX_PREAMBLE_BITS 6'h20
`define PMX_OP_READ 2'h2
`define PMX_OP_WRITE 2'h1
`define PMX_TA_WRITE 2'h2
// 5b code groups
`define PMX_CG_IDLE 5'h1F
`define PMX_CG_J 5'h18
`define PMX_CG_K 5'h11
`define PMX_BAD_SSD_NIB 4'hE
`define PMX_IDLES_END 2'h2
// timing
`define PMX_CLK_KHZ 100000
`define PMX_MII100_KHZ 25000
`define PMX_MII10_KHZ 2500
`define PMX_HALF100 (`PMX_CLK_KHZ / (2 * `PMX_MII100_KHZ))
`define PMX_HALF10 (`PMX_CLK_KHZ / (2 * `PMX_MII10_KHZ))
`define PMX_HB_NS 1000
`define PMX_HB_CYC (`PMX_HB_NS * `PMX_CLK_KHZ / 1000000)
`define PMX_LINK_MS 500
`define PMX_LINK_CYC (`PMX_LINK_MS * `PMX_CLK_KHZ)
`endif

//--- logic/pmx_phy.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pmx_defines.svh"
module pmx_phy
    import pmx_pkg::*;
#(
    parameter int LINK_CYC = `PMX_LINK_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // address straps
    input wire logic [4:0] phy_addr_strap,
    // line side inputs
    input wire logic sig_det,
    input wire logic cg_valid,
    input wire logic [4:0] cg,
    input wire logic [3:0] cg_nib,
    input wire logic rx10_active,
    input wire logic [3:0] rx10_nib,
    input wire logic link10_ok,
    input wire logic link1000_ok,
    // mii transmit from the mac
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input wire logic tx_er,
    // mii toward the mac
    output logic tx_clk,
    output logic rx_clk,
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic crs,
    output logic col,
    output logic mii_oe,
    // line side transmit
    output logic line_tx_en,
    output logic [3:0] line_txd,
    output logic line_tx_er,
    // indicators
    output logic link_10m_indicator,
    output logic link_100m_indicator,
    output logic link_1000m_indicator,
    output logic traffic_indicator,
    output logic full_duplex_indicator
);
    logic [15:0] basic_control_register;
    logic [4:0] strap_capture_register;
    logic strap_pend;
    logic link_up;
    logic isolate, full_dup, spd100;
    assign isolate = basic_control_register[`PMX_CTRL_ISOLATE];
    assign full_dup = basic_control_register[`PMX_CTRL_DUPLEX];
    assign spd100 = basic_control_register[`PMX_CTRL_SPEED];

    // strap caught one clock after release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_capture_register <= `PMX_PHY_ADDR_DEF;
            strap_pend <= 1'b1;
        end else if (strap_pend) begin
            strap_capture_register <= phy_addr_strap;
            strap_pend <= 1'b0;
        end
    end

    // three-flop filter: level moves once 2 and 3 agree
    logic [2:0] mdc_s, mdi_s;
    logic mdc_f, mdc_fd, mdi_f;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s <= 3'h0;
            mdi_s <= 3'h7;
            mdc_f <= 1'b0;
            mdc_fd <= 1'b0;
            mdi_f <= 1'b1;
        end else begin
            mdc_s <= {mdc_s[1:0], mdc};
            mdi_s <= {mdi_s[1:0], mdio_in};
            if (mdc_s[1] == mdc_s[2])
                mdc_f <= mdc_s[2];
            if (mdi_s[1] == mdi_s[2])
                mdi_f <= mdi_s[2];
            mdc_fd <= mdc_f;
        end
    end
    logic mdc_rise;
    assign mdc_rise = mdc_f & ~mdc_fd;

    // frame engine moves only on mdc edges,
    // so a paused mdc is harmless
    pmx_mf_t mf;
    logic synced;
    logic [5:0] ones;
    logic [3:0] bcnt;
    logic [1:0] op;
    logic [4:0] phy, rga;
    logic [15:0] sh;
    logic mf_wr;
    logic [4:0] mf_wa;
    logic [15:0] mf_wd;
    logic hit, bcast;
    assign hit = (phy == strap_capture_register);
    assign bcast = (phy == `PMX_BCAST_ADDR);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mf <= MF_WAIT;
            synced <= 1'b0;
            ones <= 6'h00;
            bcnt <= 4'h0;
            op <= 2'h0;
            phy <= 5'h00;
            rga <= 5'h00;
            sh <= 16'h0000;
            mf_wr <= 1'b0;
            mf_wa <= 5'h00;
            mf_wd <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            mf_wr <= 1'b0;
            if (mdc_rise) begin
                case (mf)
                    MF_WAIT: begin
                        mdio_oe <= 1'b0;
                        if (mdi_f) begin
                            // counting ones doubles as the idle bit
                            if (ones != `PMX_PREAMBLE_BITS)
                                ones <= ones + 6'h01;
                            else
                                synced <= 1'b1;
                        end else if (synced
                                || ones == `PMX_PREAMBLE_BITS) begin
                            synced <= 1'b1;
                            mf <= MF_START;
                        end else begin
                            ones <= 6'h00;
                        end
                    end
                    MF_START: begin
                        if (mdi_f) begin
                            mf <= MF_OP;
                            bcnt <= 4'h0;
                        end else begin
                            synced <= 1'b0;
                            ones <= 6'h00;
                            mf <= MF_WAIT;
                        end
                    end
                    MF_OP: begin
                        op <= {op[0], mdi_f};
                        bcnt <= bcnt + 4'h1;
                        if (bcnt == 4'h1) begin
                            bcnt <= 4'h0;
                            if ({op[0], mdi_f} == `PMX_OP_READ
                                    || {op[0], mdi_f}
                                    == `PMX_OP_WRITE) begin
                                mf <= MF_PHY;
                            end else begin
                                synced <= 1'b0;
                                ones <= 6'h00;
                                mf <= MF_WAIT;
                            end
                        end
                    end
                    MF_PHY: begin
                        phy <= {phy[3:0], mdi_f};
                        bcnt <= bcnt + 4'h1;
                        if (bcnt == 4'h4) begin
                            bcnt <= 4'h0;
                            mf <= MF_REG;
                        end
                    end
                    MF_REG: begin
                        rga <= {rga[3:0], mdi_f};
                        bcnt <= bcnt + 4'h1;
                        if (bcnt == 4'h4) begin
                            bcnt <= 4'h0;
                            mf <= MF_TA;
                            sh <= reg_view({rga[3:0], mdi_f});
                        end
                    end
                    MF_TA: begin
                        bcnt <= bcnt + 4'h1;
                        if (op == `PMX_OP_READ) begin
                            // first bit floats, then drive zero
                            mdio_oe <= hit;
                            mdio_out <= 1'b0;
                            if (bcnt == 4'h1) begin
                                bcnt <= 4'h0;
                                mf <= MF_DATA;
                                mdio_out <= sh[15];
                                sh <= {sh[14:0], 1'b0};
                            end
                        end else if (bcnt == 4'h0) begin
                            if (!mdi_f) begin
                                synced <= 1'b0;
                                ones <= 6'h00;
                                mf <= MF_WAIT;
                            end
                        end else if (mdi_f) begin
                            synced <= 1'b0;
                            ones <= 6'h00;
                            mf <= MF_WAIT;
                        end else begin
                            bcnt <= 4'h0;
                            mf <= MF_DATA;
                        end
                    end
                    MF_DATA: begin
                        bcnt <= bcnt + 4'h1;
                        if (op == `PMX_OP_READ) begin
                            mdio_out <= sh[15];
                            sh <= {sh[14:0], 1'b0};
                        end else begin
                            sh <= {sh[14:0], mdi_f};
                        end
                        if (bcnt == 4'hF) begin
                            mdio_oe <= 1'b0;
                            ones <= 6'h00;
                            mf <= MF_WAIT;
                            mf_wa <= rga;
                            mf_wd <= {sh[14:0], mdi_f};
                            mf_wr <= (op == `PMX_OP_WRITE)
                                && (hit || bcast);
                        end
                    end
                    default: mf <= MF_WAIT;
                endcase
            end
        end
    end

    // register view shared by both access paths
    function automatic logic [15:0] reg_view(input logic [4:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            `PMX_REG_CTRL: v = basic_control_register;
            `PMX_REG_STAT: begin
                v[`PMX_STAT_PRE_SUP] = 1'b1;
                v[`PMX_STAT_LINK] = link_up;
            end
            `PMX_REG_STRAP: v[4:0] = strap_capture_register;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : reg_view

    // control; a frame write wins over the port
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            basic_control_register <= `PMX_CTRL_RESET;
        else if (mf_wr && mf_wa == `PMX_REG_CTRL)
            basic_control_register <= mf_wd;
        else if (reg_wr && reg_addr == `PMX_REG_CTRL)
            basic_control_register <= reg_wdata;
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= reg_view(reg_addr);
        else
            reg_rdata <= 16'h0000;
    end

    // link monitor; long count is a parameter to shorten in sims
    logic [31:0] link_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_cnt <= 32'h0;
            link_up <= 1'b0;
        end else if (!sig_det) begin
            link_cnt <= 32'h0;
            link_up <= 1'b0;
        end else if (link_cnt < 32'(LINK_CYC - 1)) begin
            link_cnt <= link_cnt + 32'h1;
        end else begin
            link_up <= 1'b1;
        end
    end

    // mii clock divider; mii_clk toggles every half period
    logic [4:0] div;
    logic [4:0] half;
    logic mii_clk;
    assign half = spd100 ? 5'(`PMX_HALF100) : 5'(`PMX_HALF10);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 5'h00;
            mii_clk <= 1'b0;
        end else if (div >= half - 5'h01) begin
            div <= 5'h00;
            mii_clk <= ~mii_clk;
        end else begin
            div <= div + 5'h01;
        end
    end

    // 100 Mb/s receive stream; coding only runs with link up
    pmx_rx_t rx;
    logic [1:0] idles;
    logic rx_act100, bad_now;
    logic [3:0] nib100;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx <= RX_IDLE;
            idles <= 2'h0;
            rx_act100 <= 1'b0;
            bad_now <= 1'b0;
            nib100 <= 4'h0;
        end else if (!link_up || !spd100) begin
            rx <= RX_IDLE;
            idles <= 2'h0;
            rx_act100 <= 1'b0;
            bad_now <= 1'b0;
        end else if (cg_valid) begin
            if (cg == `PMX_CG_IDLE) begin
                if (idles != `PMX_IDLES_END)
                    idles <= idles + 2'h1;
            end else begin
                idles <= 2'h0;
            end
            case (rx)
                RX_IDLE: begin
                    if (cg == `PMX_CG_J && idles == `PMX_IDLES_END) begin
                        rx <= RX_JK;
                    end else if (cg != `PMX_CG_IDLE
                            && idles == `PMX_IDLES_END) begin
                        rx <= RX_BAD;
                        rx_act100 <= 1'b1;
                        bad_now <= 1'b1;
                    end
                end
                RX_JK: begin
                    rx_act100 <= 1'b1;
                    if (cg == `PMX_CG_K) begin
                        rx <= RX_DATA;
                        nib100 <= 4'h5;
                    end else begin
                        rx <= RX_BAD;
                        bad_now <= 1'b1;
                    end
                end
                RX_DATA: begin
                    nib100 <= cg_nib;
                    if (cg == `PMX_CG_IDLE && idles != 2'h0) begin
                        rx <= RX_IDLE;
                        rx_act100 <= 1'b0;
                    end
                end
                RX_BAD: begin
                    if (cg == `PMX_CG_IDLE && idles != 2'h0) begin
                        rx <= RX_IDLE;
                        rx_act100 <= 1'b0;
                        bad_now <= 1'b0;
                    end
                end
                default: rx <= RX_IDLE;
            endcase
        end
    end

    // transmit is ignored while isolated
    logic tx_on, tx_on_d, rx_on;
    assign tx_on = tx_en & ~isolate;
    assign rx_on = spd100 ? rx_act100 : rx10_active;

    // heartbeat after each 10 Mb/s transmission
    logic [7:0] hb_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_on_d <= 1'b0;
            hb_cnt <= 8'h00;
        end else begin
            tx_on_d <= tx_on;
            if (tx_on_d && !tx_on && !spd100)
                hb_cnt <= 8'(`PMX_HB_CYC);
            else if (hb_cnt != 8'h00)
                hb_cnt <= hb_cnt - 8'h01;
        end
    end

    // mii outputs, floated in isolate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk <= 1'b0;
            rx_clk <= 1'b0;
            rxd <= 4'h0;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            crs <= 1'b0;
            col <= 1'b0;
            mii_oe <= 1'b0;
        end else begin
            mii_oe <= ~isolate;
            tx_clk <= mii_clk;
            rx_clk <= mii_clk;
            rx_er <= spd100 & bad_now;
            rx_dv <= spd100 ? (rx == RX_DATA) : rx10_active;
            if (spd100 && bad_now)
                rxd <= `PMX_BAD_SSD_NIB;
            else
                rxd <= spd100 ? nib100 : rx10_nib;
            // full duplex ignores own transmit except for the 10 Mb/s heartbeat on col
            crs <= rx_on | (tx_on & ~full_dup);
            col <= (~full_dup & rx_on & tx_on)
                | (hb_cnt != 8'h00);
        end
    end

    // line side transmit path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_tx_en <= 1'b0;
            line_txd <= 4'h0;
            line_tx_er <= 1'b0;
        end else begin
            line_tx_en <= tx_on;
            line_txd <= isolate ? 4'h0 : txd;
            line_tx_er <= tx_er & ~isolate;
        end
    end

    // status indicators
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_10m_indicator <= 1'b0;
            link_100m_indicator <= 1'b0;
            link_1000m_indicator <= 1'b0;
            traffic_indicator <= 1'b0;
            full_duplex_indicator <= 1'b0;
        end else begin
            link_10m_indicator <= ~spd100 & link10_ok;
            link_100m_indicator <= spd100 & link_up;
            link_1000m_indicator <= link1000_ok;
            traffic_indicator <= rx_on | tx_on | bad_now;
            full_duplex_indicator <= full_dup;
        end
    end
endmodule : pmx_phy
`default_nettype wire

//--- logic/pmx_pkg.sv
package pmx_pkg;
    // management frame position
    typedef enum logic [2:0] {
        MF_WAIT, MF_START, MF_OP, MF_PHY, MF_REG, MF_TA, MF_DATA
    } pmx_mf_t;
    // 100 Mb/s receive stream position
    typedef enum logic [1:0] {
        RX_IDLE, RX_JK, RX_DATA, RX_BAD
    } pmx_rx_t;
endpackage : pmx_pkg

//--- tb/pmx_phy_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmx_phy_props #(
    parameter int LINK_CYC = 50
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // watched ports
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic sig_det,
    input wire logic tx_en,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic col,
    input wire logic mii_oe,
    input wire logic line_tx_en,
    input wire logic link_100m_indicator
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic mdc_q;
    logic [5:0] oe_rise;
    logic [31:0] sd_cnt;
    logic [3:0] tx_age;
    // one flop: sees mdc edges before the design does
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) mdc_q <= 1'b0;
        else mdc_q <= mdc;
    end
    // mdc rises while driving
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) oe_rise <= 6'h00;
        else if (!mdio_oe) oe_rise <= 6'h00;
        else if (mdc && !mdc_q) oe_rise <= oe_rise + 6'h01;
    end
    // steady detect length
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) sd_cnt <= 32'h0;
        else sd_cnt <= sig_det ? sd_cnt + 32'h1 : 32'h0;
    end
    // cycles since tx_en, saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) tx_age <= 4'hF;
        else tx_age <= tx_en ? 4'h0 : tx_age + {3'h0, tx_age != 4'hF};
    end
    chk_rd_pulse: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside its cycle");
    chk_link_min: assert property (
        link_100m_indicator && sig_det |-> sd_cnt >= LINK_CYC)
        else $error("link up too early");
    chk_link_drop: assert property (
        $fell(sig_det) |-> ##[1:2] !link_100m_indicator)
        else $error("link held after detect lost");
    chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("read turnaround not zero");
    chk_read_len: assert property ($fell(mdio_oe) |-> oe_rise == 6'd17)
        else $error("read drive length wrong");
    chk_col_cause: assert property ($rose(col) |-> tx_age < 4'h4)
        else $error("collision without transmit");
    chk_bad_nib: assert property (rx_er && !rx_dv |-> rxd == 4'hE)
        else $error("bad start nibble wrong");
    chk_dv_crs: assert property (rx_dv |-> crs)
        else $error("data valid without carrier");
    chk_iso_quiet: assert property (
        !mii_oe && !$past(mii_oe) |-> !line_tx_en)
        else $error("transmit passed in isolate");
    cov_link: cover property ($rose(link_100m_indicator));
    cov_read: cover property ($fell(mdio_oe));
    cov_bad: cover property (rx_er && crs);
endmodule : pmx_phy_props
`default_nettype wire

//--- tb/pmx_phy_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmx_phy_tb;
    localparam int LINK_CYC = 50;
    // design and partner pins
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00, phy_addr_strap = 5'h05, cg = 5'h1F;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic sig_det = 1'b0, cg_valid = 1'b0, tx_en = 1'b0, tx_er = 1'b0;
    logic rx10_active = 1'b0, link10_ok = 1'b0, link1000_ok = 1'b0;
    logic [3:0] cg_nib = 4'h0, rx10_nib = 4'h0, txd = 4'h0, rxd, line_txd;
    logic mdc, mdio_in, mdio_out, mdio_oe, tx_clk, rx_clk, rx_dv, rx_er;
    logic crs, col, mii_oe, line_tx_en, line_tx_er, link_10m_indicator;
    logic link_100m_indicator, link_1000m_indicator, traffic_indicator;
    logic full_duplex_indicator;
    int miscompares = 0, tests_run = 0;
    logic [16:0] got;
    // frame and expected wire bits
    typedef struct packed {
        logic [5:0] pre;
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] rg;
        logic [1:0] ta;
        logic [15:0] wd;
        logic [16:0] ex;
    } pmx_mrow_t;
    pmx_mrow_t r;
    pmx_mrow_t rows [12] = '{
        '{6'h00, 2'h2, 5'h05, 5'h00, 2'h0, 16'h0000, 17'h1FFFF},
        '{6'h20, 2'h2, 5'h05, 5'h00, 2'h0, 16'h0000, 17'h03100},
        '{6'h00, 2'h2, 5'h05, 5'h01, 2'h0, 16'h0000, 17'h00040},
        '{6'h00, 2'h2, 5'h01, 5'h00, 2'h0, 16'h0000, 17'h1FFFF},
        '{6'h00, 2'h2, 5'h00, 5'h00, 2'h0, 16'h0000, 17'h1FFFF},
        '{6'h00, 2'h1, 5'h00, 5'h00, 2'h2, 16'h3000, 17'h03000},
        '{6'h00, 2'h2, 5'h05, 5'h10, 2'h0, 16'h0000, 17'h00005},
        '{6'h00, 2'h3, 5'h05, 5'h00, 2'h3, 16'hFFFF, 17'h1FFFF},
        '{6'h00, 2'h2, 5'h05, 5'h00, 2'h0, 16'h0000, 17'h1FFFF},
        '{6'h20, 2'h1, 5'h05, 5'h00, 2'h1, 16'h3100, 17'h13100},
        '{6'h20, 2'h2, 5'h05, 5'h00, 2'h0, 16'h0000, 17'h03000},
        '{6'h00, 2'h1, 5'h05, 5'h00, 2'h2, 16'h3100, 17'h03100}};

    always #5 mclk = ~mclk;

    pmx_phy #(.LINK_CYC(LINK_CYC)) pmx_phy_inst (.*);
    pmx_sta_model pmx_sta_model_inst (.*);

    task automatic check(input string nm, input logic [16:0] seen,
        input logic [16:0] ex);
        tests_run++;
        if (seen !== ex) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check
    // register port tasks
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        got = {1'b0, reg_rdata};
    endtask : rd
    // one code group per four cycles
    task automatic cgs(input logic [4:0] c, input logic [3:0] n);
        @(posedge mclk);
        cg <= c;
        cg_nib <= n;
        cg_valid <= 1'b1;
        @(posedge mclk);
        cg_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : cgs
    // tx_clk rises in 400 cycles, +-1 for phase
    task automatic rate(input int ex);
        int n = 0;
        logic p;
        p = tx_clk;
        repeat (400) begin
            @(negedge mclk);
            n += (tx_clk && !p) ? 1 : 0;
            p = tx_clk;
        end
        check("mii clock", 17'(n >= ex - 1 && n <= ex + 1), 17'h1);
    endtask : rate
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // hang guard
    initial begin
        #500us;
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(5'h00); check("ctrl", got, 17'h03100);
        rd(5'h10); check("strap", got, 17'h00005);
        wr(5'h01, 16'hFFFF); rd(5'h01); check("stat", got, 17'h00040);
        rd(5'h1F); check("unmapped", got, 17'h0);
        foreach (rows[i]) begin
            r = rows[i];
            pmx_sta_model_inst.frame(r.pre, r.op, r.phy, r.rg, r.ta, r.wd,
                got);
            check("mgmt frame", got, r.ex);
        end
        rate(100);
        @(posedge mclk) sig_det <= 1'b1;
        repeat (LINK_CYC - 5) @(negedge mclk);
        check("link early", 17'(link_100m_indicator), 17'h0);
        repeat (10) @(negedge mclk);
        check("link up", 17'(link_100m_indicator), 17'h1);
        // bad start
        cgs(5'h1F, 4'h0); cgs(5'h1F, 4'h0); cgs(5'h0E, 4'h7);
        check("bad start", {rx_dv, rx_er, crs, rxd}, 17'h3E);
        cgs(5'h1F, 4'h0);
        check("one idle", {rx_dv, rx_er, crs, rxd}, 17'h3E);
        cgs(5'h1F, 4'h0);
        check("bad end", {rx_dv, rx_er, crs}, 17'h0);
        // full duplex packet while sending
        @(posedge mclk) tx_en <= 1'b1;
        cgs(5'h18, 4'h0);
        check("after j", {rx_dv, rx_er, crs}, 17'h0);
        cgs(5'h11, 4'h0); cgs(5'h16, 4'hA);
        check("data", {rx_dv, rx_er, crs, col, rxd}, 17'hAA);
        cgs(5'h1F, 4'h0); cgs(5'h1F, 4'h0);
        check("end", {rx_dv, crs}, 17'h0);
        // half duplex carrier and collision
        wr(5'h00, 16'h3000);
        @(posedge mclk) txd <= 4'h9;
        repeat (3) @(negedge mclk);
        check("half tx", {crs, col, line_tx_en, line_txd}, 17'h59);
        cgs(5'h18, 4'h0); cgs(5'h11, 4'h0);
        check("collision", 17'(col), 17'h1);
        @(posedge mclk) tx_en <= 1'b0;
        cgs(5'h1F, 4'h0); cgs(5'h1F, 4'h0);
        check("idle", {crs, col}, 17'h0);
        @(posedge mclk) sig_det <= 1'b0;
        repeat (3) @(negedge mclk);
        check("link lost", 17'(link_100m_indicator), 17'h0);
        // 10 Mb/s clock and heartbeat
        wr(5'h00, 16'h1000);
        rate(10);
        @(posedge mclk) tx_en <= 1'b1;
        repeat (10) @(posedge mclk);
        tx_en <= 1'b0;
        repeat (50) @(negedge mclk);
        check("heartbeat", 17'(col), 17'h1);
        repeat (70) @(negedge mclk);
        check("heartbeat end", 17'(col), 17'h0);
        // isolate
        wr(5'h00, 16'h3500);
        @(posedge mclk) tx_en <= 1'b1;
        repeat (3) @(negedge mclk);
        check("isolate", {mii_oe, line_tx_en}, 17'h0);
        pmx_sta_model_inst.frame(0, 2'h2, 5'h05, 5'h00, 2'h0, 16'h0, got);
        check("isolate mgmt", got, 17'h03500);
        // second reset: new strap, new preamble
        @(posedge mclk);
        tx_en <= 1'b0;
        phy_addr_strap <= 5'h1F;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(5'h10); check("strap again", got, 17'h0001F);
        pmx_sta_model_inst.frame(0, 2'h2, 5'h1F, 5'h00, 2'h0, 16'h0, got);
        check("no preamble", got, 17'h1FFFF);
        finish_test();
    end
endmodule : pmx_phy_tb
bind pmx_phy pmx_phy_props #(.LINK_CYC(LINK_CYC)) pmx_phy_props_inst (.*);
`default_nettype wire

//--- tb/pmx_sta_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmx_sta_model (
    // management pins
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b1;
    // pull-up when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);
    // clock rests low between frames
    initial mdc = 1'b0;
    // one bit, sampled at the rise
    task automatic bit1(input logic en, input logic b, output logic s);
        drv_en = en;
        drv_bit = b;
        #62.5 mdc = 1'b1;
        s = mdio_in;
        #62.5 mdc = 1'b0;
    endtask : bit1
    // whole frame; rd gets TA2 and data from the wire
    task automatic frame(input int pre, input logic [1:0] op,
        input logic [4:0] phy, input logic [4:0] rg, input logic [1:0] ta,
        input logic [15:0] wd, output logic [16:0] rd);
        logic [31:0] fr;
        logic s;
        fr = {2'b01, op, phy, rg, ta, wd};
        rd = 17'h1FFFF;
        for (int i = 0; i < pre; i++) bit1(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            // reads release from turnaround one
            bit1(op != 2'h2 || i > 17, fr[i], s);
            if (i < 17) rd[i] = s;
        end
        bit1(1'b0, 1'b1, s);
    endtask : frame
endmodule : pmx_sta_model
`default_nettype wire
